// File: dual_dac_register_decode.sv
// serial command decode and per-channel registers of a dual 16-bit dac
//
// Notes on behaviour
// - no-operation command changes nothing
// - local ground bit enables compensation, resets cleared
// - pin direction bit set means output, resets input
// - output pin drives last written value bit
// - input pin: value reads pin, writes ignored
// - serial-out off bit disables driver, resets cleared
// - software clear forces outputs to clear code
// - software load copies input registers to dac
// - target 010 writes selected channel code
// - target 011 writes 2-bit range, low bits
// - range 00 default, 01 and 10 wider
// - target 100 writes 6-bit gain trim
// - gain trim signed, -32 to +31, zero default
// - gain trim moves both full-scale points
// - target 101 writes 8-bit offset trim
// - offset trim signed, eighth lsb steps, zero default
// - 24-bit frame: rw, zero, target, channel, data
// - target 000 is function, channel picks sub-command
// - channel code selects a, b or both
// - read word shifts out during next frame
`timescale 1ns/100ps

module dual_dac_register_decode
   import dac_ctrl_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 arst_n,
   input  wire logic                 clk_en,
   input  wire logic                 frame_n,
   input  wire logic                 sclk,
   input  wire logic                 sdin,
   input  wire logic                 load_strobe_n,
   input  wire logic [1:0]           gp_in,
   output logic [1:0]                gp_out,
   output logic [1:0]                gp_oe,
   output logic                      sdo,
   output logic                      sdo_oe,
   output logic                      local_gnd_en,
   output logic [1:0][15:0]          dac_code,
   output trim_type [1:0]            chan_trim,
   output logic                      dac_update
);

   ////////////////////////////////////////////////////////////////////////////
   // decoding helpers

   // channel code to per-channel hit mask, bit 0 is channel a
   function automatic logic [1:0] chan_mask(input logic [2:0] code);
      logic [1:0] m;
      m = 2'h0;
      case (code)
         CH_A:    m = 2'h1;
         CH_B:    m = 2'h2;
         CH_BOTH: m = 2'h3;
         default: m = 2'h0;
      endcase
      return m;
   endfunction

   // value bit of a pin: stored level when driven, live pin when input
   function automatic logic pin_level(input logic dir, input logic val, input logic pin);
      return dir ? val : pin;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [PIN_W-1:0]     meta_q;
   logic [PIN_W-1:0]     pin_q;
   logic [PIN_W-1:0]     pin_prev_q;
   logic [PIN_W-1:0]     pin_raw;

   // pins gathered in the order of the package positions
   assign pin_raw = {gp_in[1], gp_in[0], load_strobe_n, sdin, sclk, frame_n};

   // two flops before use, a third for edge detection
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_q     <= PIN_IDLE;
         pin_q      <= PIN_IDLE;
         pin_prev_q <= PIN_IDLE;
      end else if (clk_en) begin
         meta_q     <= pin_raw;
         pin_q      <= meta_q;
         pin_prev_q <= pin_q;
      end
   end

   logic                 frame_start;
   logic                 frame_end;
   logic                 sclk_fall;
   logic                 load_fall;

   // edges of the synchronised pins; clock falls count only inside a frame
   assign frame_start = pin_prev_q[PIN_FRAME] & ~pin_q[PIN_FRAME];
   assign frame_end   = ~pin_prev_q[PIN_FRAME] & pin_q[PIN_FRAME];
   assign sclk_fall   = pin_prev_q[PIN_SCLK] & ~pin_q[PIN_SCLK] & ~pin_q[PIN_FRAME];
   assign load_fall   = pin_prev_q[PIN_LOAD] & ~pin_q[PIN_LOAD];

   ////////////////////////////////////////////////////////////////////////////
   // serial receive: data taken on falling clock, msb first

   logic [FRAME_BITS-1:0] rx_q;
   logic [CNT_W-1:0]      cnt_q;

   // count saturates so an overlong frame never aliases to a good one
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_q  <= '0;
         cnt_q <= '0;
      end else if (clk_en) begin
         if (frame_start) begin
            cnt_q <= '0;
         end else if (sclk_fall) begin
            rx_q <= {rx_q[FRAME_BITS-2:0], pin_q[PIN_SDIN]};
            if (cnt_q != FRAME_OVER) begin
               cnt_q <= cnt_q + 5'h01;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // command decode at frame end; frames of any other length are dropped

   frame_type            cmd;
   logic                 frame_ok;
   logic                 wr;
   logic                 rd;
   logic [1:0]           hit;
   logic                 fn_wr;
   logic                 ctl_wr;
   logic                 sw_clear;
   logic                 sw_load;

   assign cmd      = frame_type'(rx_q);
   assign frame_ok = frame_end & (cnt_q == FRAME_LEN);
   assign wr       = frame_ok & ~cmd.rd;
   assign rd       = frame_ok & cmd.rd;
   assign hit      = chan_mask(cmd.chan);
   assign fn_wr    = wr & (cmd.target == TGT_FUNCTION);
   // no-operation matches none of these, so nothing moves
   assign ctl_wr   = fn_wr & (cmd.chan == FN_CONTROL);
   assign sw_clear = fn_wr & (cmd.chan == FN_CLEAR);
   assign sw_load  = fn_wr & (cmd.chan == FN_LOAD);

   ////////////////////////////////////////////////////////////////////////////
   // function control bits

   logic [CTL_W-1:0]     ctl_q;
   logic [CTL_W-1:0]     ctl_d;

   // a value bit written with its own direction bit cleared in the same word keeps its old content
   always_comb begin
      ctl_d = cmd.data[CTL_W-1:0];
      if (!cmd.data[CTL_GP0_DIR]) begin
         ctl_d[CTL_GP0_VAL] = ctl_q[CTL_GP0_VAL];
      end
      if (!cmd.data[CTL_GP1_DIR]) begin
         ctl_d[CTL_GP1_VAL] = ctl_q[CTL_GP1_VAL];
      end
   end

   // control word moves only on a complete control sub-command
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctl_q <= CTL_RST;
      end else if (clk_en && ctl_wr) begin
         ctl_q <= ctl_d;
      end
   end

   // pins and enables straight from the control flops
   assign gp_oe[0]     = ctl_q[CTL_GP0_DIR];
   assign gp_oe[1]     = ctl_q[CTL_GP1_DIR];
   assign gp_out[0]    = ctl_q[CTL_GP0_VAL];
   assign gp_out[1]    = ctl_q[CTL_GP1_VAL];
   assign local_gnd_en = ctl_q[CTL_LOCAL_GND];

   ////////////////////////////////////////////////////////////////////////////
   // per-channel input, dac and trim registers

   logic [15:0]          input_q [2];
   logic [15:0]          dac_q [2];
   trim_type             trim_q [2];
   logic [1:0]           upd_ch;

   for (genvar i = 0; i < 2; i++) begin : g_chan
      logic              wr_ch;
      logic              code_wr;
      logic              range_wr;
      logic              gain_wr;
      logic              offset_wr;
      logic              copy;
      logic [15:0]       input_next;
      logic [15:0]       dac_next;

      // write strobes of this channel, one per target
      assign wr_ch      = wr & hit[i];
      assign code_wr    = wr_ch & (cmd.target == TGT_DATA);
      assign range_wr   = wr_ch & (cmd.target == TGT_RANGE);
      assign gain_wr    = wr_ch & (cmd.target == TGT_GAIN);
      assign offset_wr  = wr_ch & (cmd.target == TGT_OFFSET);
      assign input_next = code_wr ? cmd.data : input_q[i];
      // load held low during the frame updates the addressed channel at once
      assign copy       = (code_wr & ~pin_q[PIN_LOAD]) | load_fall | sw_load;
      assign upd_ch[i]  = sw_clear | copy;
      // clear wins over a load in the same cycle
      assign dac_next   = sw_clear ? CLEAR_CODE : input_next;

      always_ff @(posedge clk or negedge arst_n) begin
         if (!arst_n) begin
            input_q[i] <= CODE_RST;
            dac_q[i]   <= CODE_RST;
            trim_q[i]  <= TRIM_RST;
         end else if (clk_en) begin
            input_q[i] <= input_next;
            if (upd_ch[i]) begin
               dac_q[i] <= dac_next;
            end
            if (range_wr) begin
               trim_q[i].range_sel <= cmd.data[1:0];
            end
            // signed trim, applied by the analog path at both end points
            if (gain_wr) begin
               trim_q[i].gain_trim <= cmd.data[5:0];
            end
            if (offset_wr) begin
               trim_q[i].offset_trim <= cmd.data[7:0];
            end
         end
      end
   end

   // flatten the channel arrays onto the output ports, channel a low
   assign dac_code  = {dac_q[1], dac_q[0]};
   assign chan_trim = {trim_q[1], trim_q[0]};

   // one-cycle pulse whenever any dac register takes a new value
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dac_update <= 1'b0;
      end else if (clk_en) begin
         dac_update <= |upd_ch;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // readback selection

   logic [CTL_W-1:0]     ctl_rb;
   logic                 rd_ch;
   logic [15:0]          rd_val;

   // control word as read: value bits of input pins show the live level
   always_comb begin
      ctl_rb = ctl_q;
      ctl_rb[CTL_GP0_VAL] = pin_level(ctl_q[CTL_GP0_DIR], ctl_q[CTL_GP0_VAL], pin_q[PIN_GP0]);
      ctl_rb[CTL_GP1_VAL] = pin_level(ctl_q[CTL_GP1_DIR], ctl_q[CTL_GP1_VAL], pin_q[PIN_GP1]);
   end

   // a both-channel read returns channel a
   assign rd_ch = hit[1] & ~hit[0];

   // register named by the read frame, zero padded to the code width
   always_comb begin
      case (cmd.target)
         TGT_FUNCTION: rd_val = (cmd.chan == FN_CONTROL) ? {10'h000, ctl_rb} : 16'h0000;
         TGT_DATA:     rd_val = input_q[rd_ch];
         TGT_RANGE:    rd_val = {14'h0000, trim_q[rd_ch].range_sel};
         TGT_GAIN:     rd_val = {10'h000, trim_q[rd_ch].gain_trim};
         TGT_OFFSET:   rd_val = {8'h00, trim_q[rd_ch].offset_trim};
         default:      rd_val = 16'h0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // serial transmit: loaded at read frame end, shifted after each falling clock

   logic [FRAME_BITS-1:0] tx_q;

   // driver enable follows the synchronised frame so the pin is free between frames
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_q   <= '0;
         sdo_oe <= 1'b0;
      end else if (clk_en) begin
         if (rd) begin
            tx_q <= {RB_PAD, rd_val};
         end else if (sclk_fall) begin
            tx_q <= {tx_q[FRAME_BITS-2:0], 1'b0};
         end
         sdo_oe <= ~ctl_q[CTL_SERIAL_OUT_OFF] & ~pin_q[PIN_FRAME];
      end
   end

   assign sdo = tx_q[FRAME_BITS-1];

endmodule

// File: dac_ctrl_pkg.sv
// constants, field layouts and carrier types for the dual dac register decode
package dac_ctrl_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // serial frame geometry
   localparam int           FRAME_BITS = 24;
   localparam int           CODE_BITS  = 16;
   localparam int           CNT_W      = 5;
   localparam logic [4:0]   FRAME_LEN  = 5'h18;       // 24 clocks per frame
   localparam logic [4:0]   FRAME_OVER = 5'h19;       // saturates: frame is void
   localparam logic [7:0]   RB_PAD     = 8'h00;       // upper bits of readback word

   ////////////////////////////////////////////////////////////////////////////
   // target select codes
   localparam logic [2:0]   TGT_FUNCTION = 3'h0;
   localparam logic [2:0]   TGT_DATA     = 3'h2;
   localparam logic [2:0]   TGT_RANGE    = 3'h3;
   localparam logic [2:0]   TGT_GAIN     = 3'h4;
   localparam logic [2:0]   TGT_OFFSET   = 3'h5;

   // function sub-commands carried in the channel field
   localparam logic [2:0]   FN_NOP     = 3'h0;
   localparam logic [2:0]   FN_CONTROL = 3'h1;
   localparam logic [2:0]   FN_CLEAR   = 3'h4;
   localparam logic [2:0]   FN_LOAD    = 3'h5;

   // channel select codes
   localparam logic [2:0]   CH_A    = 3'h0;
   localparam logic [2:0]   CH_B    = 3'h1;
   localparam logic [2:0]   CH_BOTH = 3'h4;

   ////////////////////////////////////////////////////////////////////////////
   // control bit positions in the function register
   localparam int           CTL_W              = 6;
   localparam int           CTL_SERIAL_OUT_OFF = 0;
   localparam int           CTL_GP0_VAL        = 1;
   localparam int           CTL_GP0_DIR        = 2;
   localparam int           CTL_GP1_VAL        = 3;
   localparam int           CTL_GP1_DIR        = 4;
   localparam int           CTL_LOCAL_GND      = 5;

   // output range codes
   localparam logic [1:0]   RANGE_4V096 = 2'h0;
   localparam logic [1:0]   RANGE_4V201 = 2'h1;
   localparam logic [1:0]   RANGE_4V331 = 2'h2;

   // reset values
   localparam logic [5:0]   CTL_RST    = 6'h00;
   localparam logic [15:0]  CODE_RST   = 16'h0000;
   localparam logic [1:0]   RANGE_RST  = RANGE_4V096;
   localparam logic [5:0]   GAIN_RST   = 6'h00;
   localparam logic [7:0]   OFFSET_RST = 8'h00;
   // zero volts in twos complement and negative full scale in offset binary
   // are both the all-zero code, so one clear value serves both codings
   localparam logic [15:0]  CLEAR_CODE = 16'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // synchronised pin vector
   localparam int           PIN_W     = 6;
   localparam int           PIN_FRAME = 0;
   localparam int           PIN_SCLK  = 1;
   localparam int           PIN_SDIN  = 2;
   localparam int           PIN_LOAD  = 3;
   localparam int           PIN_GP0   = 4;
   localparam int           PIN_GP1   = 5;
   localparam logic [5:0]   PIN_IDLE  = 6'h0b;        // frame, clock, load idle high

   ////////////////////////////////////////////////////////////////////////////
   // carrier types
   typedef struct packed {
      logic        rd;
      logic        zero;
      logic [2:0]  target;
      logic [2:0]  chan;
      logic [15:0] data;
   } frame_type;

   typedef struct packed {
      logic [1:0]  range_sel;
      logic [5:0]  gain_trim;
      logic [7:0]  offset_trim;
   } trim_type;

   localparam trim_type     TRIM_RST = '{RANGE_RST, GAIN_RST, OFFSET_RST};

endpackage

// File: dac_ctrl_properties.sv
// port assertions for the dual dac register decode
`timescale 1ns/100ps
module dac_ctrl_properties
   import dac_ctrl_pkg::*;
(
   input wire logic             clk,
   input wire logic             arst_n,
   input wire logic             frame_n,
   input wire logic             sclk,
   input wire logic             load_strobe_n,
   input wire logic [1:0]       gp_out,
   input wire logic [1:0]       gp_oe,
   input wire logic             sdo,
   input wire logic             sdo_oe,
   input wire logic             local_gnd_en,
   input wire logic [1:0][15:0] dac_code,
   input wire trim_type [1:0]   chan_trim,
   input wire logic             dac_update
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////////////////////////////////////
   // registers move only after a frame has closed or the load pin fell
   a_trim_after_frame: assert property ($changed(chan_trim) |-> $past(frame_n, 2))
      else $error("trim changed inside a frame");
   a_ctl_after_frame: assert property ($changed({gp_oe, gp_out, local_gnd_en}) |-> $past(frame_n, 2))
      else $error("control changed inside a frame");
   a_code_has_cause: assert property ($changed(dac_code) |-> $past(frame_n, 2) || !$past(load_strobe_n, 2))
      else $error("dac code changed without cause");
   // update strobe is a single pulse tied to a dac write
   a_update_after_code: assert property ($changed(dac_code) |-> ##[0:1] dac_update)
      else $error("dac write without update pulse");
   a_update_single: assert property (dac_update |=> !dac_update)
      else $error("update pulse longer than one cycle");
   a_update_has_cause: assert property (dac_update |-> $past(frame_n, 2) || !$past(load_strobe_n, 2))
      else $error("update pulse without cause");
   // serial output driver off outside frames, data steady while clock high
   a_sdo_idle_off: assert property (frame_n [*5] |-> !sdo_oe)
      else $error("serial output driven outside a frame");
   a_sdo_hold_high: assert property ((sclk && !frame_n) [*3] |-> $stable(sdo))
      else $error("serial output moved while clock high");
   c_update: cover property (dac_update);
   c_gp_drive: cover property ($rose(gp_oe[0]));
   c_sdo_on: cover property (sdo_oe && sdo);
endmodule
bind dual_dac_register_decode dac_ctrl_properties chk (
   .clk, .arst_n, .frame_n, .sclk, .load_strobe_n, .gp_out, .gp_oe, .sdo, .sdo_oe,
   .local_gnd_en, .dac_code, .chan_trim, .dac_update
);

// File: dac_host_model.sv
// host serial master that frames commands and captures readback
`timescale 1ns/100ps
module dac_host_model (
   input  wire logic clk,
   output logic      frame_n,
   output logic      sclk,
   output logic      sdin,
   input  wire logic sdo,
   input  wire logic sdo_oe
);
   logic oe_seen;
   // idle: frame and clock high and still
   initial begin
      frame_n = 1'b1;
      sclk = 1'b1;
      sdin = 1'b0;
      oe_seen = 1'b0;
   end
   // n bits of w msb first; rd holds sdo seen just before each fall
   task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] rd);
      rd = '0;
      @(posedge clk);
      #1 frame_n = 1'b0;
      for (int i = 23; i > 23 - n; i--) begin
         sdin = w[i];
         sclk = 1'b1;
         repeat (4) @(posedge clk);
         // a released output reads as the inverse of what the device last drove
         #1 rd[i] = sdo_oe ? sdo : ~sdo;
         oe_seen = oe_seen | sdo_oe;
         sclk = 1'b0;
         repeat (4) @(posedge clk);
         #1;
      end
      sclk = 1'b1;
      repeat (4) @(posedge clk);
      #1 frame_n = 1'b1;
      sdin = ~sdin; // released line must not keep its value
      repeat (6) @(posedge clk);
      #1;
   endtask
endmodule

// File: tb_dual_dac_register_decode.sv
// self-checking bench for the dual dac register decode
`timescale 1ns/100ps
module tb_dual_dac_register_decode
   import dac_ctrl_pkg::*;
;
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin err_total++; \
   $display("MISMATCH %s expected %h seen %h", nm, ex, gt); end end
   logic             clk, arst_n, load_strobe_n, frame_n, sclk, sdin, sdo, sdo_oe;
   logic             clk_en;
   logic [7:0]       upd_count = 8'h00;
   logic             local_gnd_en, dac_update;
   logic [1:0]       gp_in, gp_out, gp_oe;
   logic [1:0][15:0] dac_code;
   trim_type [1:0]   chan_trim;
   logic [23:0]      rd;
   int               err_total = 0;
   int               samples_checked = 0;
   typedef struct packed {
      logic [2:0]  tgt;
      logic [2:0]  ch;
      logic [15:0] wdat;
      logic [2:0]  rch;
      logic [15:0] exp;
   } row_type;
   row_type rows [8] = '{
      '{TGT_RANGE, CH_A, 16'hfffd, CH_A, 16'h0001},
      '{TGT_RANGE, CH_B, 16'h0002, CH_B, 16'h0002},
      '{TGT_GAIN, CH_A, 16'hffe0, CH_A, 16'h0020},
      '{TGT_GAIN, CH_B, 16'h001f, CH_B, 16'h001f},
      '{TGT_OFFSET, CH_A, 16'hff80, CH_A, 16'h0080},
      '{TGT_OFFSET, CH_B, 16'h007f, CH_B, 16'h007f},
      '{TGT_DATA, CH_A, 16'h1234, CH_A, 16'h1234},
      '{TGT_DATA, CH_BOTH, 16'hbeef, CH_B, 16'hbeef}};
   ////////////////////////////////////////////////////////////////////////
   dual_dac_register_decode dut (.clk, .arst_n, .clk_en, .frame_n, .sclk, .sdin,
      .load_strobe_n, .gp_in, .gp_out, .gp_oe, .sdo, .sdo_oe, .local_gnd_en, .dac_code,
      .chan_trim, .dac_update);
   dac_host_model host (.clk, .frame_n, .sclk, .sdin, .sdo, .sdo_oe);
   // 50 MHz clock
   initial clk = 1'b0;
   always #10 clk = ~clk;
   // counts update pulses, one per dac update event even when both channels change
   always @(posedge clk) upd_count <= upd_count + {7'h00, dac_update};
   function automatic logic [23:0] fw(logic r, logic [2:0] t, logic [2:0] c, logic [15:0] d);
      return {r, 1'b0, t, c, d};
   endfunction
   task automatic ctl(input logic [5:0] d);
      host.xfer(fw(1'b0, TGT_FUNCTION, FN_CONTROL, {10'h000, d}), 24, rd);
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // watchdog cuts a hang short
   initial begin
      #1000000;
      err_total++;
      give_verdict;
   end
   ////////////////////////////////////////////////////////////////////////
   // main sequence: reset, table rows, then hand-written cases
   initial begin
      arst_n = 1'b0;
      clk_en = 1'b1;
      load_strobe_n = 1'b1;
      gp_in = 2'b10;
      repeat (2) @(posedge clk);
      #1 arst_n = 1'b1;
      repeat (3) @(posedge clk);
      `CHK("trim reset", 32'h0, chan_trim)
      `CHK("ctl reset", 35'h0, {gp_oe, local_gnd_en, dac_code})
      foreach (rows[i]) begin
         host.xfer(fw(1'b0, rows[i].tgt, rows[i].ch, rows[i].wdat), 24, rd);
         host.xfer(fw(1'b1, rows[i].tgt, rows[i].rch, 16'h0000), 24, rd);
         host.xfer(fw(1'b0, TGT_FUNCTION, FN_NOP, 16'h0000), 24, rd);
         `CHK("readback", {8'h00, rows[i].exp}, rd)
      end
      `CHK("trim b", {2'h2, 6'h1f, 8'h7f}, chan_trim[1])
      host.xfer(fw(1'b0, TGT_RANGE, CH_A, 16'h0002), 23, rd);
      host.xfer(fw(1'b0, TGT_FUNCTION, FN_NOP, 16'hffff), 24, rd);
      `CHK("trim a", {2'h1, 6'h20, 8'h80}, chan_trim[0])
      `CHK("pending", 32'h0, dac_code)
      `CHK("sdo on", 1'b1, host.oe_seen)
      ctl(6'h3f);
      host.oe_seen = 1'b0;
      `CHK("pins on", 5'h1f, {gp_oe, gp_out, local_gnd_en})
      host.xfer(fw(1'b0, TGT_FUNCTION, FN_NOP, 16'h0000), 24, rd);
      `CHK("sdo off", 1'b0, host.oe_seen)
      ctl(6'h34);
      `CHK("pins low", 5'h19, {gp_oe, gp_out, local_gnd_en})
      ctl(6'h2a);
      `CHK("pins in", 5'h01, {gp_oe, gp_out, local_gnd_en})
      host.xfer(fw(1'b1, TGT_FUNCTION, FN_CONTROL, 16'h0000), 24, rd);
      host.xfer(fw(1'b0, TGT_FUNCTION, FN_NOP, 16'h0000), 24, rd);
      `CHK("ctl read", 24'h000028, rd)
      ctl(6'h00);
      `CHK("gnd off", 1'b0, local_gnd_en)
      host.xfer(fw(1'b0, TGT_FUNCTION, FN_LOAD, 16'h0000), 24, rd);
      `CHK("sw load", 32'hbeefbeef, dac_code)
      host.xfer(fw(1'b0, TGT_FUNCTION, FN_CLEAR, 16'h0000), 24, rd);
      `CHK("sw clear", 32'h0, dac_code)
      host.xfer(fw(1'b0, TGT_DATA, CH_B, 16'h5555), 24, rd);
      `CHK("held", 32'h0, dac_code)
      @(posedge clk);
      #1 load_strobe_n = 1'b0;
      repeat (8) @(posedge clk);
      `CHK("pin load", 32'h5555beef, dac_code)
      host.xfer(fw(1'b0, TGT_DATA, CH_A, 16'h0f0f), 24, rd);
      `CHK("direct", 32'h55550f0f, dac_code)
      load_strobe_n = 1'b1;
      host.xfer(fw(1'b0, TGT_DATA, CH_B, 16'h00ff), 24, rd);
      clk_en = 1'b0;
      load_strobe_n = 1'b0;
      repeat (8) @(posedge clk);
      #1;
      `CHK("frozen", 32'h55550f0f, dac_code)
      clk_en = 1'b1;
      repeat (8) @(posedge clk);
      #1;
      `CHK("thawed", 32'h00ff0f0f, dac_code)
      `CHK("update pulses", 8'h05, upd_count)
      give_verdict;
   end
endmodule
